// >>> design/lock_pkg.sv
// constants for the lock detector and bleed control register bank
// assumes a 100 MHz core clock and a same-clock phase error measurement
package lock_pkg;
    // register offsets
    localparam logic [7:0] ADDR_BLEED   = 8'h26;
    localparam logic [7:0] ADDR_LOCKWIN = 8'h27;
    localparam logic [7:0] ADDR_LOCKCNT = 8'h28;

    // reset values
    localparam logic [7:0] RST_BLEED   = 8'h32;
    localparam logic [7:0] RST_LOCKWIN = 8'hc5;
    localparam logic [7:0] RST_LOCKCNT = 8'h03;

    // field positions in the window and bleed control register
    localparam int BIAS_HI      = 7;
    localparam int BIAS_LO      = 6;
    localparam int PREC_BIT     = 5;
    localparam int GATE_BIT     = 4;
    localparam int BLEED_EN_BIT = 3;
    localparam int VREG_BIT     = 2;
    localparam int PBS_HI       = 1;
    localparam int PBS_LO       = 0;

    // field positions in the count and loss control register
    localparam int CNT_HI  = 2;
    localparam int CNT_LO  = 1;
    localparam int LOL_BIT = 0;
    localparam logic [7:0] LOCKCNT_WMASK = 8'h07;

    // widths
    localparam int ERR_W = 16;
    localparam int CNT_W = 14;

    // lock windows in ps: fractional precision follows the bias delay,
    // integer precision scales it by 2.4/5
    localparam logic [ERR_W-1:0] WIN_FRAC_0_PS = 16'h1388;
    localparam logic [ERR_W-1:0] WIN_FRAC_1_PS = 16'h1770;
    localparam logic [ERR_W-1:0] WIN_FRAC_2_PS = 16'h1f40;
    localparam logic [ERR_W-1:0] WIN_FRAC_3_PS = 16'h2ee0;
    localparam logic [ERR_W-1:0] WIN_INT_0_PS  = 16'h0960;
    localparam logic [ERR_W-1:0] WIN_INT_1_PS  = 16'h0b40;
    localparam logic [ERR_W-1:0] WIN_INT_2_PS  = 16'h0f00;
    localparam logic [ERR_W-1:0] WIN_INT_3_PS  = 16'h1680;

    // lock cycle count base, doubled per code step
    localparam logic [CNT_W-1:0] LOCK_BASE_CYCLES = 14'h0400;

    // reference loss timeout
    localparam int CLK_PERIOD_NS   = 10;
    localparam int REF_LOSS_NS     = 10240;
    localparam int REF_LOSS_CYCLES = REF_LOSS_NS / CLK_PERIOD_NS;
    localparam int REF_W           = $clog2(REF_LOSS_CYCLES + 1);

    function automatic logic [ERR_W-1:0] window_ps(input logic [1:0] bias,
                                                   input logic       prec);
        logic [ERR_W-1:0] w;
        w = WIN_FRAC_0_PS;
        unique case ({prec, bias})
            3'b000: w = WIN_FRAC_0_PS;
            3'b001: w = WIN_FRAC_1_PS;
            3'b010: w = WIN_FRAC_2_PS;
            3'b011: w = WIN_FRAC_3_PS;
            3'b100: w = WIN_INT_0_PS;
            3'b101: w = WIN_INT_1_PS;
            3'b110: w = WIN_INT_2_PS;
            3'b111: w = WIN_INT_3_PS;
        endcase
        return w;
    endfunction : window_ps

    function automatic logic [CNT_W-1:0] lock_target(input logic [1:0] code);
        return LOCK_BASE_CYCLES << code;
    endfunction : lock_target
endpackage : lock_pkg

// >>> design/lock_cfg_if.sv
// carrier for configuration fields from the register bank to the core
// assumes one clock domain; fields are register outputs
`timescale 1ns/1ns
interface lock_cfg_if;
    logic [7:0] bleed_mag;
    logic [1:0] bias;
    logic       prec;
    logic       gate;
    logic       bleed_en;
    logic       vreg_dis;
    logic [1:0] pbs;
    logic [1:0] cnt_sel;
    logic       loss_of_lock_enable;

    modport regs (output bleed_mag, bias, prec, gate, bleed_en, vreg_dis, pbs, cnt_sel, loss_of_lock_enable);
    modport core (input  bleed_mag, bias, prec, gate, bleed_en, vreg_dis, pbs, cnt_sel, loss_of_lock_enable);
endinterface : lock_cfg_if

// >>> design/lock_regs.sv
// register bank behind the serial port's decoded byte access
// assumes one-cycle write and read strobes from the serial front end
`timescale 1ns/1ns
module lock_regs (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_r,
    lock_cfg_if.regs        cfg
);
    logic [7:0] bleed_r;
    logic [7:0] lockwin_r;
    logic [7:0] lockcnt_r;

    // bleed magnitude, whole byte
    always_ff @(posedge clk) begin
        if (srst) begin
            bleed_r <= lock_pkg::RST_BLEED;
        end else if (wr_en && addr == lock_pkg::ADDR_BLEED) begin
            bleed_r <= wdata;
        end
    end

    // window, precision, bleed and regulator controls, all writable
    always_ff @(posedge clk) begin
        if (srst) begin
            lockwin_r <= lock_pkg::RST_LOCKWIN;
        end else if (wr_en && addr == lock_pkg::ADDR_LOCKWIN) begin
            lockwin_r <= wdata;
        end
    end

    // upper bits are read-only zero, so writes are masked
    always_ff @(posedge clk) begin
        if (srst) begin
            lockcnt_r <= lock_pkg::RST_LOCKCNT;
        end else if (wr_en && addr == lock_pkg::ADDR_LOCKCNT) begin
            lockcnt_r <= wdata & lock_pkg::LOCKCNT_WMASK;
        end
    end

    // registered read; unmapped offsets answer zero
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (rd_en) begin
            unique case (addr)
                lock_pkg::ADDR_BLEED:   rdata_r <= bleed_r;
                lock_pkg::ADDR_LOCKWIN: rdata_r <= lockwin_r;
                lock_pkg::ADDR_LOCKCNT: rdata_r <= lockcnt_r;
                default:                rdata_r <= 8'h00;
            endcase
        end
    end

    // field fan-out
    assign cfg.bleed_mag = bleed_r;
    assign cfg.bias      = lockwin_r[lock_pkg::BIAS_HI:lock_pkg::BIAS_LO];
    assign cfg.prec      = lockwin_r[lock_pkg::PREC_BIT];
    assign cfg.gate      = lockwin_r[lock_pkg::GATE_BIT];
    assign cfg.bleed_en  = lockwin_r[lock_pkg::BLEED_EN_BIT];
    assign cfg.vreg_dis  = lockwin_r[lock_pkg::VREG_BIT];
    assign cfg.pbs       = lockwin_r[lock_pkg::PBS_HI:lock_pkg::PBS_LO];
    assign cfg.cnt_sel   = lockcnt_r[lock_pkg::CNT_HI:lock_pkg::CNT_LO];
    assign cfg.loss_of_lock_enable    = lockcnt_r[lock_pkg::LOL_BIT];
endmodule : lock_regs

// >>> design/ref_watch.sv
// reference presence watchdog on the comparison strobe
// assumes the strobe is a one-cycle pulse per comparison on clk
`timescale 1ns/1ns
module ref_watch (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic pfd_strobe,
    output logic      ref_lost_r
);
    logic [lock_pkg::REF_W-1:0] idle_r;

    // counts clocks since the last comparison; saturates at the timeout
    always_ff @(posedge clk) begin
        if (srst || pfd_strobe) begin
            idle_r <= '0;
        end else if (idle_r != lock_pkg::REF_W'(lock_pkg::REF_LOSS_CYCLES)) begin
            idle_r <= idle_r + 1'b1;
        end
    end

    // level, held until comparisons return
    always_ff @(posedge clk) begin
        if (srst || pfd_strobe) begin
            ref_lost_r <= 1'b0;
        end else begin
            ref_lost_r <= (idle_r == lock_pkg::REF_W'(lock_pkg::REF_LOSS_CYCLES));
        end
    end
endmodule : ref_watch

// >>> design/lock_detect_bleed_control.sv
// digital lock detector with bleed current and regulator controls
// assumes phase error in ps and a one-cycle comparison strobe, both on clk;
// register accesses arrive already decoded from the serial port
`timescale 1ns/1ns

// What this block does
// - bleed magnitude byte at 0x26, resets 0x32
// - bias field picks 5, 6, 8, 12 ns
// - precision bit picks 5 or 2.4 ns window at bias code 0, scaling each bias window by 2.4/5
// - gated bleed follows lock detect
// - bleed enable bit switches negative bleed
// - regulator disable bit, resets to one
// - 0x27 resets 0xc5, low field resets to one and is writable
// - lock after 1024 to 8192 in-window cycles
// - loss of reference drops lock when enabled
// - 0x28 resets 0x03, upper bits read zero
module lock_detect_bleed_control (
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       reg_wr_en,
    input  wire logic                       reg_rd_en,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    input  wire logic                       pfd_strobe,
    input  wire logic [lock_pkg::ERR_W-1:0] pfd_phase_err_ps,
    output logic      [7:0]                 bleed_current_magnitude,
    output logic                            bleed_current_on,
    output logic                            vco_regulator_disable,
    output logic                            lock_detect,
    output logic      [lock_pkg::ERR_W-1:0] lock_window_ps
);
    lock_cfg_if cfg ();

    logic [lock_pkg::CNT_W-1:0] cnt_r;
    logic [lock_pkg::CNT_W-1:0] cnt_nxt;
    logic [lock_pkg::CNT_W-1:0] target;
    logic                       lock_r;
    logic                       ref_lost;
    logic                       in_window;

    lock_regs u_regs (
        .clk     (clk),
        .srst    (srst),
        .wr_en   (reg_wr_en),
        .rd_en   (reg_rd_en),
        .addr    (reg_addr),
        .wdata   (reg_wdata),
        .rdata_r (reg_rdata),
        .cfg     (cfg.regs)
    );

    ref_watch u_ref (
        .clk        (clk),
        .srst       (srst),
        .pfd_strobe (pfd_strobe),
        .ref_lost_r (ref_lost)
    );

    // window threshold held in a flop so the comparator sees a stable value
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_window_ps <= lock_pkg::window_ps(lock_pkg::RST_LOCKWIN[lock_pkg::BIAS_HI:
                                                  lock_pkg::BIAS_LO],
                                                  lock_pkg::RST_LOCKWIN[lock_pkg::PREC_BIT]);
        end else begin
            lock_window_ps <= lock_pkg::window_ps(cfg.bias, cfg.prec);
        end
    end

    // comparison and count target
    assign in_window = (pfd_phase_err_ps <= lock_window_ps);
    assign target    = lock_pkg::lock_target(cfg.cnt_sel);
    assign cnt_nxt   = cnt_r + 1'b1;

    // in-window counter; a lowered target takes effect on the next strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (cfg.loss_of_lock_enable && ref_lost) begin
            cnt_r <= '0;
        end else if (pfd_strobe) begin
            if (!in_window) begin
                cnt_r <= '0;
            end else if (cnt_nxt >= target) begin
                cnt_r <= target;
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    // lock flag; without loss-of-lock enabled a vanished reference keeps it
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_r <= 1'b0;
        end else if (cfg.loss_of_lock_enable && ref_lost) begin
            lock_r <= 1'b0;
        end else if (pfd_strobe) begin
            if (!in_window) begin
                lock_r <= 1'b0;
            end else if (cnt_nxt >= target) begin
                lock_r <= 1'b1;
            end
        end
    end

    assign lock_detect = lock_r;

    // bleed gating lags lock by one clock; harmless against pump timescales
    always_ff @(posedge clk) begin
        if (srst) begin
            bleed_current_on <= 1'b0;
        end else begin
            bleed_current_on <= cfg.bleed_en && (!cfg.gate || lock_r);
        end
    end

    // analog-facing copies of register fields
    always_ff @(posedge clk) begin
        if (srst) begin
            bleed_current_magnitude <= lock_pkg::RST_BLEED;
            vco_regulator_disable   <= lock_pkg::RST_LOCKWIN[lock_pkg::VREG_BIT];
        end else begin
            bleed_current_magnitude <= cfg.bleed_mag;
            vco_regulator_disable   <= cfg.vreg_dis;
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_bleed_reset;
        $fell(srst) |-> cfg.bleed_mag == lock_pkg::RST_BLEED;
    endproperty
    a_bleed_reset: assert property (p_bleed_reset)
        else $error("bleed magnitude not at reset value");

    property p_bleed_write;
        reg_wr_en && reg_addr == lock_pkg::ADDR_BLEED
            |-> ##2 bleed_current_magnitude == $past(reg_wdata, 2);
    endproperty
    a_bleed_write: assert property (p_bleed_write)
        else $error("bleed magnitude write not reflected");

    property p_bias_wide;
        !cfg.prec && cfg.bias == 2'h3 |=> lock_window_ps == lock_pkg::WIN_FRAC_3_PS;
    endproperty
    a_bias_wide: assert property (p_bias_wide)
        else $error("widest bias window wrong");

    property p_prec_int;
        cfg.prec |=> lock_window_ps <= lock_pkg::WIN_INT_3_PS;
    endproperty
    a_prec_int: assert property (p_prec_int)
        else $error("integer precision window too wide");

    property p_gated_bleed;
        cfg.bleed_en && cfg.gate && !lock_r |=> !bleed_current_on;
    endproperty
    a_gated_bleed: assert property (p_gated_bleed)
        else $error("gated bleed on without lock");

    property p_bleed_enable;
        !cfg.bleed_en |=> !bleed_current_on;
    endproperty
    a_bleed_enable: assert property (p_bleed_enable)
        else $error("bleed on while disabled");

    property p_vreg_reset;
        $fell(srst) |-> cfg.vreg_dis ##1 vco_regulator_disable;
    endproperty
    a_vreg_reset: assert property (p_vreg_reset)
        else $error("regulator disable not set after reset");

    property p_win_reset;
        $fell(srst) |-> {cfg.bias, cfg.prec, cfg.gate, cfg.bleed_en, cfg.vreg_dis, cfg.pbs}
                        == lock_pkg::RST_LOCKWIN;
    endproperty
    a_win_reset: assert property (p_win_reset)
        else $error("window register reset value wrong");

    property p_lock_count;
        $rose(lock_detect) |-> cnt_r == target && $past(pfd_strobe);
    endproperty
    a_lock_count: assert property (p_lock_count)
        else $error("lock asserted before count reached");

    property p_loss;
        cfg.loss_of_lock_enable && ref_lost && lock_detect |=> !lock_detect && cnt_r == '0;
    endproperty
    a_loss: assert property (p_loss)
        else $error("lock held after reference loss");

    property p_cnt_read;
        reg_rd_en && reg_addr == lock_pkg::ADDR_LOCKCNT |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_cnt_read: assert property (p_cnt_read)
        else $error("reserved count bits read nonzero");

    property p_out_window;
        pfd_strobe && !in_window |=> !lock_detect && cnt_r == '0;
    endproperty
    a_out_window: assert property (p_out_window)
        else $error("out-of-window cycle did not restart count");

    // analog-facing copies trail their register fields by exactly one clock
    property p_mag_copy;
        !$past(srst) |-> bleed_current_magnitude == $past(cfg.bleed_mag);
    endproperty
    a_mag_copy: assert property (p_mag_copy)
        else $error("bleed magnitude copy does not follow register");

    property p_vreg_copy;
        !$past(srst) |-> vco_regulator_disable == $past(cfg.vreg_dis);
    endproperty
    a_vreg_copy: assert property (p_vreg_copy)
        else $error("regulator disable copy does not follow register");

    // bleed switching, ungated and gated by lock
    property p_ungated_on;
        cfg.bleed_en && !cfg.gate |=> bleed_current_on;
    endproperty
    a_ungated_on: assert property (p_ungated_on)
        else $error("ungated bleed not on while enabled");

    property p_gated_locked;
        cfg.bleed_en && cfg.gate && lock_r |=> bleed_current_on;
    endproperty
    a_gated_locked: assert property (p_gated_locked)
        else $error("gated bleed off while locked");

    // window sizes per bias code; the widest is checked above
    property p_bias_0;
        !cfg.prec && cfg.bias == 2'h0 |=> lock_window_ps == lock_pkg::WIN_FRAC_0_PS;
    endproperty
    a_bias_0: assert property (p_bias_0)
        else $error("narrowest bias window wrong");

    property p_bias_1;
        !cfg.prec && cfg.bias == 2'h1 |=> lock_window_ps == lock_pkg::WIN_FRAC_1_PS;
    endproperty
    a_bias_1: assert property (p_bias_1)
        else $error("second bias window wrong");

    property p_bias_2;
        !cfg.prec && cfg.bias == 2'h2 |=> lock_window_ps == lock_pkg::WIN_FRAC_2_PS;
    endproperty
    a_bias_2: assert property (p_bias_2)
        else $error("third bias window wrong");

    property p_int_0;
        cfg.prec && cfg.bias == 2'h0 |=> lock_window_ps == lock_pkg::WIN_INT_0_PS;
    endproperty
    a_int_0: assert property (p_int_0)
        else $error("integer precision base window wrong");

    // lock only comes from an in-window comparison
    property p_lock_in_window;
        $rose(lock_detect) |-> $past(in_window);
    endproperty
    a_lock_in_window: assert property (p_lock_in_window)
        else $error("lock asserted on an out-of-window cycle");

    // without a strobe or a loss event, lock and count stand still
    property p_lock_stable;
        !pfd_strobe && !(cfg.loss_of_lock_enable && ref_lost) |=> $stable(lock_detect);
    endproperty
    a_lock_stable: assert property (p_lock_stable)
        else $error("lock changed without a comparison");

    property p_cnt_stable;
        !pfd_strobe && !(cfg.loss_of_lock_enable && ref_lost) |=> $stable(cnt_r);
    endproperty
    a_cnt_stable: assert property (p_cnt_stable)
        else $error("count changed without a comparison");

    // loss of lock disabled: a silent reference keeps the lock
    property p_no_lol;
        !cfg.loss_of_lock_enable && lock_detect && !pfd_strobe |=> lock_detect;
    endproperty
    a_no_lol: assert property (p_no_lol)
        else $error("lock dropped with loss of lock disabled");

    property p_ref_clear;
        pfd_strobe |=> !ref_lost;
    endproperty
    a_ref_clear: assert property (p_ref_clear)
        else $error("reference loss held after a comparison");

    // readback of each register; a write in the same cycle is left out
    property p_read_bleed;
        reg_rd_en && !reg_wr_en && reg_addr == lock_pkg::ADDR_BLEED
            |=> reg_rdata == cfg.bleed_mag;
    endproperty
    a_read_bleed: assert property (p_read_bleed)
        else $error("bleed register readback wrong");

    property p_read_win;
        reg_rd_en && !reg_wr_en && reg_addr == lock_pkg::ADDR_LOCKWIN
            |=> reg_rdata == {cfg.bias, cfg.prec, cfg.gate, cfg.bleed_en, cfg.vreg_dis, cfg.pbs};
    endproperty
    a_read_win: assert property (p_read_win)
        else $error("window register readback wrong");

    property p_read_cnt;
        reg_rd_en && !reg_wr_en && reg_addr == lock_pkg::ADDR_LOCKCNT
            |=> reg_rdata == {5'h00, cfg.cnt_sel, cfg.loss_of_lock_enable};
    endproperty
    a_read_cnt: assert property (p_read_cnt)
        else $error("count register readback wrong");

    // count code and loss enable come out of reset at their defaults
    property p_cnt_reset;
        $fell(srst) |-> {cfg.cnt_sel, cfg.loss_of_lock_enable}
                        == lock_pkg::RST_LOCKCNT[lock_pkg::CNT_HI:lock_pkg::LOL_BIT];
    endproperty
    a_cnt_reset: assert property (p_cnt_reset)
        else $error("count register reset value wrong");

    c_lock:      cover property ($rose(lock_detect));
    c_ref_loss:  cover property (lock_detect && cfg.loss_of_lock_enable && ref_lost);
    c_gated_on:  cover property (cfg.gate && bleed_current_on);
    c_restart:   cover property (lock_detect && pfd_strobe && !in_window);
    c_int_win:   cover property (cfg.prec && pfd_strobe && in_window);
endmodule : lock_detect_bleed_control

// >>> testbench/testbench.sv
// self-checking bench for the lock detector and bleed control block
// assumes the byte strobe register port and a same-clock comparison strobe
`timescale 1ns/1ns
module testbench;
    logic        clk;
    logic        srst;
    logic        reg_wr_en;
    logic        reg_rd_en;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        pfd_strobe;
    logic [lock_pkg::ERR_W-1:0] pfd_phase_err_ps;
    logic [7:0]  bleed_current_magnitude;
    logic        bleed_current_on;
    logic        vco_regulator_disable;
    logic        lock_detect;
    logic [lock_pkg::ERR_W-1:0] lock_window_ps;
    int          n_fail;
    int          comparisons;
    // expected windows indexed by {precision, bias}, in ps
    logic [15:0] win_tab [8];

    lock_detect_bleed_control uut (
        .clk                     (clk),
        .srst                    (srst),
        .reg_wr_en               (reg_wr_en),
        .reg_rd_en               (reg_rd_en),
        .reg_addr                (reg_addr),
        .reg_wdata               (reg_wdata),
        .reg_rdata               (reg_rdata),
        .pfd_strobe              (pfd_strobe),
        .pfd_phase_err_ps        (pfd_phase_err_ps),
        .bleed_current_magnitude (bleed_current_magnitude),
        .bleed_current_on        (bleed_current_on),
        .vco_regulator_disable   (vco_regulator_disable),
        .lock_detect             (lock_detect),
        .lock_window_ps          (lock_window_ps)
    );

    // 100 MHz core clock
    always #5 clk = ~clk;

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask : check_out

    // one-cycle write strobe, then let the copies settle two cycles
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        tick(2);
    endtask : reg_write

    // data is registered at the read edge and holds, so sample a cycle later
    task automatic reg_read_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge clk);
        reg_rd_en = 1'b0;
        @(negedge clk);
        check_reg(reg_rdata, exp);
    endtask : reg_read_check

    // back-to-back comparison strobes with one error value
    task automatic strobes(input int n, input logic [15:0] err);
        repeat (n) begin
            @(negedge clk);
            pfd_strobe       = 1'b1;
            pfd_phase_err_ps = err;
        end
        @(negedge clk);
        pfd_strobe = 1'b0;
        tick(2);
    endtask : strobes

    // watchdog sized well above the roughly 22k cycles of the sequence
    initial begin
        #600000;
        n_fail++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        win_tab = '{16'h1388, 16'h1770, 16'h1f40, 16'h2ee0,
                    16'h0960, 16'h0b40, 16'h0f00, 16'h1680};
        clk = 1'b0;
        srst = 1'b1;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pfd_strobe = 1'b0;
        pfd_phase_err_ps = 16'h0000;
        tick(16);
        srst = 1'b0;
        // reset values at the ports and through the register port
        check_out(bleed_current_magnitude, 16'h0032);
        check_out(vco_regulator_disable, 16'h0001);
        check_out(lock_detect, 16'h0000);
        check_out(lock_window_ps, 16'h2ee0);
        reg_read_check(8'h26, 8'h32);
        reg_read_check(8'h27, 8'hc5);
        reg_read_check(8'h28, 8'h03);
        // bleed byte round trip and its copy
        reg_write(8'h26, 8'ha5);
        check_out(bleed_current_magnitude, 16'h00a5);
        reg_read_check(8'h26, 8'ha5);
        // software setting for feedback divide 32 and 900 uA pump current
        reg_write(8'h26, 8'((4 * 900 * 100) / (32 * 375)));
        check_out(bleed_current_magnitude, 16'h001e);
        reg_read_check(8'h26, 8'h1e);
        // reserved upper bits stay zero; unmapped offset is ignored
        reg_write(8'h28, 8'hff);
        reg_read_check(8'h28, 8'h07);
        reg_write(8'h29, 8'h5a);
        reg_read_check(8'h29, 8'h00);
        // every bias and precision pair, regulator turned on meanwhile
        for (int i = 0; i < 8; i++) begin
            reg_write(8'h27, {i[1:0], i[2], 5'h01});
            check_out(lock_window_ps, win_tab[i]);
            check_out(vco_regulator_disable, 16'h0000);
        end
        // widest window, gated bleed on, reserved field left at one
        reg_write(8'h27, 8'hd9);
        reg_read_check(8'h27, 8'hd9);
        // each count code: one short of target, target, then a miss
        for (int c = 0; c < 4; c++) begin
            reg_write(8'h28, {5'h00, c[1:0], 1'b1});
            strobes((1024 << c) - 1, 16'h2ee0);
            check_out(lock_detect, 16'h0000);
            check_out(bleed_current_on, 16'h0000);
            strobes(1, 16'h2ee0);
            check_out(lock_detect, 16'h0001);
            check_out(bleed_current_on, 16'h0001);
            strobes(1, 16'h2ee1);
            check_out(lock_detect, 16'h0000);
            check_out(bleed_current_on, 16'h0000);
        end
        // after a miss the count starts again from zero
        reg_write(8'h28, 8'h01);
        strobes(1000, 16'h2ee0);
        strobes(1, 16'h2ee1);
        strobes(1000, 16'h2ee0);
        check_out(lock_detect, 16'h0000);
        // ungated bleed follows the enable bit only
        reg_write(8'h27, 8'hc9);
        check_out(bleed_current_on, 16'h0001);
        reg_write(8'h27, 8'hc1);
        check_out(bleed_current_on, 16'h0000);
        // reference removal with loss of lock enabled
        strobes(1024, 16'h2ee0);
        check_out(lock_detect, 16'h0001);
        tick(990);
        check_out(lock_detect, 16'h0001);
        tick(60);
        check_out(lock_detect, 16'h0000);
        // with loss of lock disabled the lock is held
        reg_write(8'h28, 8'h00);
        strobes(1024, 16'h2ee0);
        check_out(lock_detect, 16'h0001);
        tick(1100);
        check_out(lock_detect, 16'h0001);
        stop_test();
    end
endmodule : testbench
